//--- verilog/scb_map.svh
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCB_OFS_FLAGS 8'h00
`define SCB_OFS_DATA 8'h04
`define SCB_OFS_BAUD 8'h08
`define SCB_OFS_CTRL2 8'h10
`define SCB_OFS_RXEXT 8'h14
`define SCB_OFS_TXEXT 8'h18

// ----------------------------------------
// Control two bit positions
// ----------------------------------------
`define SCB_TIE_BIT 7
`define SCB_TX_DONE_IRQ_ENABLE_BIT 6
`define SCB_RIE_BIT 5
`define SCB_QUIET_LINE_IRQ_ENABLE_BIT 4
`define SCB_TE_BIT 3
`define SCB_RE_BIT 2
`define SCB_MUTE_BIT 1
`define SCB_BRK_BIT 0

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define SCB_TX_BUFFER_EMPTY_FLAG_BIT 7
`define SCB_TC_BIT 6
`define SCB_RX_FULL_FLAG_BIT 5
`define SCB_IDLE_BIT 4
`define SCB_OR_BIT 3

// ----------------------------------------
// Baud select fields
// ----------------------------------------
`define SCB_COARSE_HI 7
`define SCB_COARSE_LO 6
`define SCB_TXDIV_HI 5
`define SCB_TXDIV_LO 3
`define SCB_RXDIV_HI 2
`define SCB_RXDIV_LO 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SCB_CTRL2_RST 8'h00
`define SCB_BAUD_RST 8'h00
`define SCB_EXT_RST 8'h00
`define SCB_FRAME_BITS 4'ha
`define SCB_OS_MID 4'h7
`define SCB_OS_LAST 4'hf
`define SCB_IDLE_OS_TICKS 8'ha0

`endif

//--- verilog/scb_pkg.sv
// Purpose: Shared types of the serial control block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in scb_map.svh
package scb_pkg;

  // ----------------------------------------
  // Frame kinds and states
  // ----------------------------------------
  typedef enum logic [1:0] {SCB_K_DATA, SCB_K_PREAMBLE, SCB_K_BREAK} scb_kind_t;
  typedef enum logic [1:0] {SCB_T_IDLE, SCB_T_GAP, SCB_T_SHIFT} scb_tx_state_t;
  typedef enum logic [1:0] {SCB_R_HUNT, SCB_R_START, SCB_R_DATA, SCB_R_STOP} scb_rx_state_t;

endpackage

//--- verilog/scb_rate_gen.sv
// Purpose: Baud generator, 16x sample tick and bit tick
// Assumes: Divider settings may change at any time
// Notes: Extended divisor zero means conventional mode
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_rate_gen
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] coarse_div_select,
  input wire logic [2:0] div_select,
  input wire logic [7:0] ext_divisor,
  output logic os_tick,
  output logic bit_tick
);

  // ----------------------------------------
  // Total division ahead of the 16 stage
  // ----------------------------------------
  function automatic logic [18:0] total_div(input logic [1:0] cs, input logic [2:0] ds,
                                             input logic [7:0] ext);
    logic [18:0] pr;
    logic [18:0] v;
    pr = 19'd1;
    if (cs == 2'b01) pr = 19'd3;
    else if (cs == 2'b10) pr = 19'd4;
    else if (cs == 2'b11) pr = 19'd13;
    v = pr << ds;
    if (ext != 8'h00) v = 19'(v * 19'(ext));
    return v;
  endfunction

  logic [18:0] cnt_q;
  logic [3:0] phase_q;
  wire logic [18:0] div_w = total_div(coarse_div_select, div_select, ext_divisor);
  wire logic wrap_w = (cnt_q >= div_w - 19'd1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 19'h0;
      phase_q <= 4'h0;
      os_tick <= 1'b0;
      bit_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= wrap_w ? 19'h0 : cnt_q + 19'd1;
      os_tick <= wrap_w;
      bit_tick <= wrap_w && (phase_q == `SCB_OS_LAST);
      if (wrap_w) phase_q <= phase_q + 4'h1;
    end
  end

endmodule

//--- verilog/scb_tx_shifter.sv
// Purpose: Output shifter for data, preamble and break frames
// Assumes: bit_tick pulses once per bit time
// Notes: Ten-bit frames, LSB first, line idles high
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_tx_shifter
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic gap_req,
  input wire logic go,
  input wire scb_kind_t kind,
  input wire logic [7:0] data,
  output logic ack,
  output logic done,
  output logic busy,
  output logic txd
);

  scb_tx_state_t st_q;
  logic [9:0] sh_q;
  logic [3:0] cnt_q;
  logic data_q;
  // Frames start on a bit tick so the start bit lasts a whole bit time
  wire logic start_w = (st_q == SCB_T_IDLE) && go && !gap_req && bit_tick;
  wire logic [9:0] frame_w = (kind == SCB_K_DATA) ? {1'b1, data, 1'b0} :
                             (kind == SCB_K_PREAMBLE) ? 10'h3ff : 10'h000;
  wire logic last_w = (st_q == SCB_T_SHIFT) && bit_tick && (cnt_q == 4'h1);

  assign ack = start_w;
  assign busy = (st_q != SCB_T_IDLE);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= SCB_T_IDLE;
      sh_q <= 10'h3ff;
      cnt_q <= 4'h0;
      data_q <= 1'b0;
      done <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      done <= last_w && data_q;
      case (st_q)
        SCB_T_IDLE:
        begin
          txd <= 1'b1;
          if (gap_req)
          begin
            st_q <= SCB_T_GAP;
          end
          else if (go && bit_tick)
          begin
            sh_q <= frame_w;
            cnt_q <= `SCB_FRAME_BITS;
            data_q <= (kind == SCB_K_DATA);
            st_q <= SCB_T_SHIFT;
          end
        end
        SCB_T_GAP:
        begin
          if (bit_tick) st_q <= SCB_T_IDLE;
        end
        default:
        begin
          txd <= sh_q[0];
          if (bit_tick)
          begin
            sh_q <= {1'b1, sh_q[9:1]};
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) st_q <= SCB_T_IDLE;
          end
        end
      endcase
    end
  end

endmodule

//--- verilog/scb_core.sv
// Purpose: Serial control, data port and baud selection behind APB
// Assumes: rxd synchronous to clk; APB pready always high
// Notes: 8N1 frames; parity, noise and framing checks left out
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "scb_map.svh"

// What this block does
// - Tx-empty enable gates buffer-empty onto interrupt
// - Done enable gates tx-complete onto interrupt
// - Rx enable gates overrun or full
// - Quiet enable gates idle-line flag
// - Transmitter starts frames only with tx_enable
// - Enable pulse mid-word queues idle preamble
// - One bit time wait after enabling
// - Pin released when both enables off
// - rx_enable starts start-bit hunting
// - Mute set by software, cleared on wake
// - Break sent while set; one after pulse
// - Data port splits tx and rx buffers
// - Coarse codes give 3, 4, 13
// - Tx divider is power of two
// - Rx divider is power of two
// - Nonzero rx extended divisor enables it
// - Nonzero tx extended divisor enables it
// - Buffer-empty cleared: flag access, data write
// - Rx-full cleared: flag access, data read
module scb_core
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic irq
);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic acc_w = psel && penable;
  wire logic wr_w = acc_w && pwrite;
  wire logic rd_w = acc_w && !pwrite;
  wire logic hit_flags_w = (paddr == `SCB_OFS_FLAGS);
  wire logic hit_data_w = (paddr == `SCB_OFS_DATA);
  wire logic hit_baud_w = (paddr == `SCB_OFS_BAUD);
  wire logic hit_ctrl_w = (paddr == `SCB_OFS_CTRL2);
  wire logic hit_rxext_w = (paddr == `SCB_OFS_RXEXT);
  wire logic hit_txext_w = (paddr == `SCB_OFS_TXEXT);
  wire logic mapped_w = hit_flags_w || hit_data_w || hit_baud_w || hit_ctrl_w ||
                        hit_rxext_w || hit_txext_w;

  assign pready = 1'b1;
  assign pslverr = acc_w && !mapped_w;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] baud_q;
  logic [7:0] rx_ext_q;
  logic [7:0] tx_ext_q;
  logic [7:0] tx_hold_q;
  logic [7:0] rx_hold_q;
  logic mute_q;
  logic flags_seen_q;
  logic tx_buffer_empty_flag_q;
  logic tc_q;
  logic rx_full_flag_q;
  logic idle_q;
  logic ovr_q;
  logic te_ever_q;
  logic te_prev_q;
  logic brk_prev_q;
  logic pre_pend_q;
  logic brk_pend_q;
  logic gap_pend_q;

  wire logic tie_w = ctrl_q[`SCB_TIE_BIT];
  wire logic tx_done_irq_enable_w = ctrl_q[`SCB_TX_DONE_IRQ_ENABLE_BIT];
  wire logic rie_w = ctrl_q[`SCB_RIE_BIT];
  wire logic quiet_line_irq_enable_w = ctrl_q[`SCB_QUIET_LINE_IRQ_ENABLE_BIT];
  wire logic te_w = ctrl_q[`SCB_TE_BIT];
  wire logic re_w = ctrl_q[`SCB_RE_BIT];
  wire logic brk_w = ctrl_q[`SCB_BRK_BIT];

  wire logic data_wr_w = wr_w && hit_data_w;
  wire logic data_rd_w = rd_w && hit_data_w;
  wire logic clr_tx_w = data_wr_w && flags_seen_q;
  wire logic clr_rx_w = data_rd_w && flags_seen_q;
  wire logic ctrl_wr_w = wr_w && hit_ctrl_w;

  // ----------------------------------------
  // Baud generators
  // ----------------------------------------
  logic tx_bit_tick;
  logic rx_os_tick;

  scb_rate_gen u_tx_rate (
    .clk(clk),
    .rst(rst),
    .coarse_div_select(baud_q[`SCB_COARSE_HI:`SCB_COARSE_LO]),
    .div_select(baud_q[`SCB_TXDIV_HI:`SCB_TXDIV_LO]),
    .ext_divisor(tx_ext_q),
    .os_tick(),
    .bit_tick(tx_bit_tick)
  );

  scb_rate_gen u_rx_rate (
    .clk(clk),
    .rst(rst),
    .coarse_div_select(baud_q[`SCB_COARSE_HI:`SCB_COARSE_LO]),
    .div_select(baud_q[`SCB_RXDIV_HI:`SCB_RXDIV_LO]),
    .ext_divisor(rx_ext_q),
    .os_tick(rx_os_tick),
    .bit_tick()
  );

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic tx_ack;
  logic tx_done;
  logic tx_busy;
  logic tx_line;
  scb_kind_t kind_w;
  wire logic te_rise_w = te_w && !te_prev_q;
  wire logic te_fall_w = !te_w && te_prev_q;
  wire logic brk_fall_w = !brk_w && brk_prev_q;
  // Break outranks preamble, preamble outranks data
  assign kind_w = (brk_w || brk_pend_q) ? SCB_K_BREAK :
                  pre_pend_q ? SCB_K_PREAMBLE : SCB_K_DATA;
  wire logic tx_go_w = te_w && (brk_w || brk_pend_q || pre_pend_q || !tx_buffer_empty_flag_q);
  wire logic load_data_w = tx_ack && (kind_w == SCB_K_DATA);

  scb_tx_shifter u_tx (
    .clk(clk),
    .rst(rst),
    .bit_tick(tx_bit_tick),
    .gap_req(gap_pend_q),
    .go(tx_go_w),
    .kind(kind_w),
    .data(tx_hold_q),
    .ack(tx_ack),
    .done(tx_done),
    .busy(tx_busy),
    .txd(tx_line)
  );

  assign txd = tx_line;
  // Pin is taken as soon as the transmitter is enabled
  assign txd_oe = te_w || (te_ever_q && re_w);

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  scb_rx_state_t rx_st_q;
  logic [3:0] os_cnt_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] idle_cnt_q;
  logic idle_armed_q;
  logic idle_hit_q;
  logic rx_frame_q;

  wire logic idle_evt_w = re_w && rx_os_tick && (rx_st_q == SCB_R_HUNT) && rxd &&
                          !idle_hit_q && (idle_cnt_q == `SCB_IDLE_OS_TICKS - 8'h1);
  // Muted frames are dropped and never set flags
  wire logic rx_load_w = rx_frame_q && !mute_q && !rx_full_flag_q;
  wire logic rx_ovr_w = rx_frame_q && !mute_q && rx_full_flag_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_q <= SCB_R_HUNT;
      os_cnt_q <= 4'h0;
      bit_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_frame_q <= 1'b0;
    end
    else
    begin
      rx_frame_q <= 1'b0;
      if (!re_w)
      begin
        rx_st_q <= SCB_R_HUNT;
      end
      else if (rx_os_tick)
      begin
        os_cnt_q <= os_cnt_q + 4'h1;
        case (rx_st_q)
          SCB_R_HUNT:
          begin
            os_cnt_q <= 4'h0;
            if (!rxd) rx_st_q <= SCB_R_START;
          end
          SCB_R_START:
          begin
            if (os_cnt_q == `SCB_OS_MID)
            begin
              os_cnt_q <= 4'h0;
              bit_cnt_q <= 3'h0;
              rx_st_q <= rxd ? SCB_R_HUNT : SCB_R_DATA;
            end
          end
          SCB_R_DATA:
          begin
            if (os_cnt_q == `SCB_OS_LAST)
            begin
              rx_sh_q <= {rxd, rx_sh_q[7:1]};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              if (bit_cnt_q == 3'h7) rx_st_q <= SCB_R_STOP;
            end
          end
          default:
          begin
            if (os_cnt_q == `SCB_OS_LAST)
            begin
              rx_frame_q <= 1'b1;
              rx_st_q <= SCB_R_HUNT;
            end
          end
        endcase
      end
    end
  end

  // Idle line: ten bit times high, reported once per quiet spell
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      idle_cnt_q <= 8'h00;
      idle_hit_q <= 1'b0;
    end
    else if (!re_w || (rx_st_q != SCB_R_HUNT) || (rx_os_tick && !rxd))
    begin
      idle_cnt_q <= 8'h00;
      idle_hit_q <= 1'b0;
    end
    else if (rx_os_tick && !idle_hit_q)
    begin
      idle_cnt_q <= idle_cnt_q + 8'h1;
      if (idle_evt_w) idle_hit_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registers and flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `SCB_CTRL2_RST;
      baud_q <= `SCB_BAUD_RST;
      rx_ext_q <= `SCB_EXT_RST;
      tx_ext_q <= `SCB_EXT_RST;
      tx_hold_q <= 8'h00;
      rx_hold_q <= 8'h00;
    end
    else
    begin
      if (ctrl_wr_w) ctrl_q <= pwdata[7:0];
      if (wr_w && hit_baud_w) baud_q <= pwdata[7:0];
      if (wr_w && hit_rxext_w) rx_ext_q <= pwdata[7:0];
      if (wr_w && hit_txext_w) tx_ext_q <= pwdata[7:0];
      if (data_wr_w) tx_hold_q <= pwdata[7:0];
      if (rx_load_w) rx_hold_q <= rx_sh_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mute_q <= 1'b0;
      idle_armed_q <= 1'b0;
      flags_seen_q <= 1'b0;
      tx_buffer_empty_flag_q <= 1'b1;
      tc_q <= 1'b1;
      rx_full_flag_q <= 1'b0;
      idle_q <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      // Hardware wake wins over a software write in the same cycle
      if (idle_evt_w && mute_q) mute_q <= 1'b0;
      else if (ctrl_wr_w) mute_q <= pwdata[`SCB_MUTE_BIT];
      if (acc_w && hit_flags_w) flags_seen_q <= 1'b1;
      else if (data_wr_w || data_rd_w) flags_seen_q <= 1'b0;
      tx_buffer_empty_flag_q <= load_data_w || (tx_buffer_empty_flag_q && !clr_tx_w);
      tc_q <= tx_done || (tc_q && !clr_tx_w);
      rx_full_flag_q <= rx_load_w || (rx_full_flag_q && !clr_rx_w);
      ovr_q <= rx_ovr_w || (ovr_q && !clr_rx_w);
      idle_q <= (idle_evt_w && idle_armed_q && !mute_q) || (idle_q && !clr_rx_w);
      if (rx_load_w) idle_armed_q <= 1'b1;
      else if (idle_evt_w) idle_armed_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit sequencing
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      te_ever_q <= 1'b0;
      te_prev_q <= 1'b0;
      brk_prev_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      gap_pend_q <= 1'b0;
    end
    else
    begin
      te_prev_q <= te_w;
      brk_prev_q <= brk_w;
      if (te_w) te_ever_q <= 1'b1;
      // Gap after enabling; a re-enable mid-word asks for a preamble instead
      if (te_rise_w && !tx_busy) gap_pend_q <= 1'b1;
      else if (gap_pend_q && !tx_busy) gap_pend_q <= 1'b0;
      if (te_fall_w && tx_busy) pre_pend_q <= 1'b1;
      else if (tx_ack && kind_w == SCB_K_PREAMBLE) pre_pend_q <= 1'b0;
      if (brk_fall_w) brk_pend_q <= 1'b1;
      else if (tx_ack && kind_w == SCB_K_BREAK) brk_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data and interrupt
  // ----------------------------------------
  wire logic [7:0] flags_w = {tx_buffer_empty_flag_q, tc_q, rx_full_flag_q, idle_q, ovr_q, 3'b000};
  wire logic [7:0] rsel_w = hit_flags_w ? flags_w :
                            hit_data_w ? rx_hold_q :
                            hit_baud_w ? baud_q :
                            hit_ctrl_w ? {ctrl_q[7:2], mute_q, ctrl_q[0]} :
                            hit_rxext_w ? rx_ext_q :
                            hit_txext_w ? tx_ext_q : 8'h00;
  wire logic irq_w = (tie_w && tx_buffer_empty_flag_q) ||
                     (tx_done_irq_enable_w && tc_q) ||
                     (rie_w && (ovr_q || rx_full_flag_q)) ||
                     (quiet_line_irq_enable_w && idle_q);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      irq <= 1'b0;
    end
    else
    begin
      prdata <= (psel && !penable && !pwrite) ? {24'h0, rsel_w} : prdata;
      irq <= irq_w;
    end
  end

endmodule

//--- tb/scb_remote.sv
// Purpose: Far-end serial device: sends 8N1 frames, captures txd frames
// Assumes: Bit time given in clk cycles
// Notes: Line idles at mark level between frames
`timescale 1ns/1ps
module scb_remote (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bt = 16;
  int frames = 0;
  logic [7:0] got;
  logic stop_bit;

  initial rxd = 1'b1;

  // ----------------------------------------
  // Sender
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input int t);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (t) @(posedge clk);
    end
  endtask

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Waits for mark after each frame so a held break counts once
  always @(posedge clk)
    if (txd === 1'b0)
    begin
      repeat (bt / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bt) @(posedge clk);
        got[i] = txd;
      end
      repeat (bt) @(posedge clk);
      stop_bit = txd;
      frames++;
      while (txd !== 1'b1) @(posedge clk);
    end
endmodule

//--- tb/scb_core_props.sv
// Purpose: Port-level checks of the serial control block
// Assumes: pready always high, so every access phase completes
// Notes: Shadows written registers from the bus
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_core_props
  import scb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic irq
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [7:0] ctrl_q, baud_q, txe_q;
  logic [11:0] run_q;
  logic te_ever_q, sure_q, txd_prev_q;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire mapped = paddr inside {`SCB_OFS_FLAGS, `SCB_OFS_DATA, `SCB_OFS_BAUD,
    `SCB_OFS_CTRL2, `SCB_OFS_RXEXT, `SCB_OFS_TXEXT};

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl_q <= 8'h00;
      baud_q <= 8'h00;
      txe_q <= 8'h00;
      te_ever_q <= 1'b0;
      sure_q <= 1'b1;
      run_q <= 12'h000;
      txd_prev_q <= 1'b1;
    end
    else
    begin
      if (wr && paddr == `SCB_OFS_CTRL2)
        ctrl_q <= pwdata[7:0];
      if (wr && paddr == `SCB_OFS_BAUD)
        baud_q <= pwdata[7:0];
      if (wr && paddr == `SCB_OFS_TXEXT)
        txe_q <= pwdata[7:0];
      te_ever_q <= te_ever_q | (wr && paddr == `SCB_OFS_CTRL2 && pwdata[3]);
      // Any data write may clear buffer-empty, so stop trusting it
      if (wr && paddr == `SCB_OFS_DATA)
        sure_q <= 1'b0;
      run_q <= (txd != txd_prev_q) ? 12'h000 : run_q + 12'h001;
      txd_prev_q <= txd;
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_rd(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_owner:
  assert property (txd_oe == (te_ever_q && (ctrl_q[3] || ctrl_q[2])))
    else $error("pin ownership wrong");
  a_quiet_off:
  assert property (!te_ever_q |-> txd) else $error("txd active before enable");
  a_irq_masked:
  assert property (ctrl_q[7:4] == 4'h0 && $past(ctrl_q[7:4]) == 4'h0 |-> !irq)
    else $error("irq with sources masked");
  a_irq_empty:
  assert property ($rose(ctrl_q[7]) && sure_q |-> ##[1:2] irq)
    else $error("no irq for empty buffer");
  a_unmapped_err:
  assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  a_read_zero:
  assert property (acc && !pwrite |-> prdata[31:8] == 24'h0 && (mapped || prdata[7:0] == 8'h00))
    else $error("read data not zero");
  a_ctrl_back:
  assert property (s_rd(`SCB_OFS_CTRL2) |-> (prdata[7:0] & 8'hfd) == ($past(ctrl_q) & 8'hfd))
    else $error("control readback wrong");
  a_baud_back:
  assert property (s_rd(`SCB_OFS_BAUD) |-> prdata[7:0] == $past(baud_q))
    else $error("baud readback wrong");
  a_txext_back:
  assert property (s_rd(`SCB_OFS_TXEXT) |-> prdata[7:0] == $past(txe_q))
    else $error("tx divisor readback wrong");
  a_low_run_bits:
  assert property ($rose(txd) && baud_q == 8'h00 && txe_q == 8'h00 |-> run_q[3:0] == 4'hf)
    else $error("low run not whole bits");
endmodule

bind scb_core scb_core_props u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .txd_oe, .irq);

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the serial control block
// Assumes: Zero-wait APB slave; 16 clk per bit at baud 00
// Notes: Waits are bounded by the watchdog
`timescale 1ns/1ps
`include "scb_map.svh"
module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd, txd_oe, irq, e;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata;
  int err_count = 0;
  int samples_checked = 0;

  scb_core dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .txd_oe, .irq);
  scb_remote remote (.clk, .txd, .rxd);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps one assignment per signal per step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_frame(input int n);
    for (int k = 0; k < 5000 && remote.frames < n; k++)
      @(posedge clk);
    if (remote.frames < n)
    begin
      err_count++;
      $display("MISMATCH t=%0t frame timeout", $time);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset();
    logic [7:0] a [4] = '{`SCB_OFS_CTRL2, `SCB_OFS_BAUD, `SCB_OFS_RXEXT, `SCB_OFS_TXEXT};
    cmp(txd_oe, 1'b0);
    rd(`SCB_OFS_FLAGS);
    cmp(q, 8'hc0);
    foreach (a[i])
    begin
      rd(a[i]);
      cmp(q, 8'h00);
    end
  endtask
  task automatic s_regs();
    wr(`SCB_OFS_BAUD, 8'ha5);
    wr(`SCB_OFS_RXEXT, 8'h7e);
    wr(`SCB_OFS_TXEXT, 8'h81);
    wr(`SCB_OFS_FLAGS, 8'h00);
    rd(`SCB_OFS_BAUD);
    cmp(q, 8'ha5);
    rd(`SCB_OFS_RXEXT);
    cmp(q, 8'h7e);
    rd(`SCB_OFS_TXEXT);
    cmp(q, 8'h81);
    rd(`SCB_OFS_FLAGS);
    cmp(q, 8'hc0);
    rd(8'h0c);
    cmp({e, q}, 9'h100);
    wr(`SCB_OFS_BAUD, 8'h00);
    wr(`SCB_OFS_RXEXT, 8'h00);
    wr(`SCB_OFS_TXEXT, 8'h00);
  endtask
  task automatic s_irq();
    logic [7:0] en [2] = '{8'h80, 8'h40};
    foreach (en[i])
    begin
      wr(`SCB_OFS_CTRL2, en[i]);
      @(posedge clk);
      cmp(irq, 1'b1);
      wr(`SCB_OFS_CTRL2, 8'h00);
      @(posedge clk);
      cmp(irq, 1'b0);
    end
  endtask
  task automatic s_tx();
    int n;
    wr(`SCB_OFS_CTRL2, 8'h08);
    cmp(txd_oe, 1'b1);
    n = remote.frames + 1;
    rd(`SCB_OFS_FLAGS);
    wr(`SCB_OFS_DATA, 8'ha5);
    // Second write after the load, with no flag access before it
    while (txd !== 1'b0) @(posedge clk);
    wr(`SCB_OFS_DATA, 8'h5a);
    wait_frame(n);
    cmp({remote.stop_bit, remote.got}, 9'h1a5);
    repeat (400) @(posedge clk);
    cmp(remote.frames, n);
    rd(`SCB_OFS_FLAGS);
    cmp(q, 8'hc0);
  endtask
  task automatic s_rx();
    wr(`SCB_OFS_BAUD, 8'h01);
    wr(`SCB_OFS_CTRL2, 8'h2c);
    remote.send(8'h3c, 32);
    for (int k = 0; k < 40 && q[5] !== 1'b1; k++)
      rd(`SCB_OFS_FLAGS);
    cmp(q[5], 1'b1);
    cmp(irq, 1'b1);
    rd(`SCB_OFS_DATA);
    cmp(q, 8'h3c);
    rd(`SCB_OFS_FLAGS);
    cmp(q[5], 1'b0);
    wr(`SCB_OFS_CTRL2, 8'h2e);
    rd(`SCB_OFS_CTRL2);
    cmp(q[1], 1'b1);
    repeat (400) @(posedge clk);
    rd(`SCB_OFS_CTRL2);
    cmp(q[1], 1'b0);
    wr(`SCB_OFS_BAUD, 8'h00);
    wr(`SCB_OFS_CTRL2, 8'h08);
  endtask
  task automatic s_rates();
    logic [7:0] bd [5] = '{8'h40, 8'h80, 8'hc0, 8'h08, 8'h00};
    logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    int bt [5] = '{48, 64, 208, 32, 48};
    int n, w;
    foreach (bd[i])
    begin
      wr(`SCB_OFS_BAUD, bd[i]);
      wr(`SCB_OFS_TXEXT, ex[i]);
      remote.bt = bt[i];
      n = remote.frames + 1;
      rd(`SCB_OFS_FLAGS);
      wr(`SCB_OFS_DATA, 8'hfe);
      w = 0;
      while (txd !== 1'b0) @(posedge clk);
      while (txd === 1'b0)
      begin
        @(posedge clk);
        w++;
      end
      cmp(w, 2 * bt[i]);
      wait_frame(n);
      cmp(remote.got, 8'hfe);
      repeat (bt[i]) @(posedge clk);
    end
    wr(`SCB_OFS_BAUD, 8'h00);
    wr(`SCB_OFS_TXEXT, 8'h00);
    remote.bt = 16;
  endtask
  task automatic s_break();
    int n;
    n = remote.frames + 1;
    wr(`SCB_OFS_CTRL2, 8'h09);
    wait_frame(n);
    wr(`SCB_OFS_CTRL2, 8'h08);
    cmp({remote.stop_bit, remote.got}, 9'h000);
    repeat (500) @(posedge clk);
    cmp(txd, 1'b1);
    cmp(remote.frames, n + 1);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_regs();
    s_irq();
    s_tx();
    s_rx();
    s_rates();
    s_break();
    summarize();
  end
  // Whole run needs roughly 7000 cycles
  initial
  begin
    #(25 * 60000);
    err_count++;
    summarize();
  end
endmodule
